// ### pmn_defs.svh
// Constants for the paired-single multiply and negate unit.
// Assumes a 32-bit AHB-Lite register window with byte offsets below 8'h40.
`ifndef PMN_DEFS_SVH
`define PMN_DEFS_SVH
// -------------------------------------------------------------------------
// Register byte offsets
// -------------------------------------------------------------------------
`define PMN_OFF_CFG 8'h00
`define PMN_OFF_INSTR 8'h04
`define PMN_OFF_SRC_A0 8'h08
`define PMN_OFF_SRC_A1 8'h0C
`define PMN_OFF_SRC_B0 8'h10
`define PMN_OFF_SRC_B1 8'h14
`define PMN_OFF_SRC_C0 8'h18
`define PMN_OFF_SRC_C1 8'h1C
`define PMN_OFF_FP_STATUS_CONTROL_REG 8'h20
`define PMN_OFF_RES0 8'h24
`define PMN_OFF_RES1 8'h28
`define PMN_OFF_STATUS 8'h2C
`define PMN_OFF_IRQ_STAT 8'h30
`define PMN_OFF_IRQ_MASK 8'h34
// -------------------------------------------------------------------------
// Instruction encodings
// -------------------------------------------------------------------------
`define PMN_OP_PRIMARY 6'h04
`define PMN_XO_MUL 5'h19
`define PMN_XO_MULS0 5'h0C
`define PMN_XO_MULS1 5'h0D
`define PMN_XO_NABS 10'h088
`define PMN_XO_NEG 10'h028
// -------------------------------------------------------------------------
// Status and control register bit positions
// -------------------------------------------------------------------------
`define PMN_FX 31
`define PMN_FEX 30
`define PMN_VX 29
`define PMN_OX 28
`define PMN_UX 27
`define PMN_ZX 26
`define PMN_XX 25
`define PMN_SIGNALLING_NAN_INVALID 24
`define PMN_INF_MINUS_INF_INVALID 23
`define PMN_INF_TIMES_ZERO_INVALID 20
`define PMN_FR 18
`define PMN_FI 17
`define PMN_RESULT_CLASS_SIGN_FIELD_HI 16
`define PMN_RESULT_CLASS_SIGN_FIELD_LO 12
`define PMN_VE 7
`define PMN_OE 6
`define PMN_UE 5
`define PMN_ZE 4
`define PMN_XE 3
`define PMN_RN_HI 1
`define PMN_RN_LO 0
`define PMN_VX_MASK 32'h01F8_0700
// -------------------------------------------------------------------------
// Rounding modes, float constants, event bits, status bit
// -------------------------------------------------------------------------
`define PMN_RM_NEAR 2'b00
`define PMN_RM_ZERO 2'b01
`define PMN_RM_PINF 2'b10
`define PMN_RM_NINF 2'b11
`define PMN_EXP_ALL 8'hFF
`define PMN_EXP_TOP 11'sh0FF
`define PMN_BIAS 11'sh07F
`define PMN_QNAN 32'h7FC0_0000
`define PMN_QBIT 32'h0040_0000
`define PMN_MAXF 31'h7F7F_FFFF
`define PMN_NORM_STEPS 47
`define PMN_EV_DONE 0
`define PMN_EV_ILL 1
`define PMN_EV_FEX 2
`define PMN_ST_ILL 9
`endif

// ### pmn_pkg.sv
// Types for the paired-single multiply and negate unit.
// Assumes pmn_defs.svh sits in the same folder.
package pmn_pkg;
   `include "pmn_defs.svh"

   typedef enum logic [2:0] {
      PMN_S_IDLE = 3'b001,
      PMN_S_DATA = 3'b010,
      PMN_S_EXEC = 3'b100
   } pmn_state_t;

   typedef struct packed {
      logic [31:0] res;
      logic fr;
      logic fi;
      logic ox;
      logic ux;
      logic xx;
      logic signalling_nan_invalid;
      logic inf_times_zero_invalid;
   } pmn_mul_t;

   typedef struct packed {
      pmn_state_t st;
      logic [7:0] a_addr;
      logic a_write;
      logic a_map;
      logic hready;
      logic hresp;
      logic [31:0] hrdata;
      logic irq;
      logic paired_single_enable;
      logic [31:0] instr;
      logic [5:0][31:0] src;
      logic [31:0] fp_status_control_reg;
      logic [31:0] res0;
      logic [31:0] res1;
      logic [3:0] cr1;
      logic [4:0] dest;
      logic ill;
      logic [2:0] stat;
      logic [2:0] mask;
   } pmn_regs_t;

   localparam pmn_regs_t PMN_RST = '{st: PMN_S_IDLE, hready: 1'b1, default: '0};
endpackage

// ### pmn_unit.sv
// Paired-single multiply and negate execution unit behind an AHB-Lite slave.
// Assumes a single AHB-Lite master, word transfers only, and that software
// loads operands before writing the instruction word.
//
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
// Macros do not travel with the package import, so the unit names them itself.
`include "pmn_defs.svh"

module pmn_unit
   import pmn_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   output logic irq
);

   pmn_regs_t q;
   pmn_regs_t n;

   // ----------------------------------------------------------------------
   // Arithmetic helpers
   // ----------------------------------------------------------------------

   // Single-precision multiply of one lane. Tiny results flush to a signed
   // zero; that trades gradual underflow for a much smaller datapath.
   function automatic pmn_mul_t pmn_fmul(input logic [31:0] a, input logic [31:0] c,
                                         input logic [1:0] rm);
      pmn_mul_t r;
      logic s, an, cn, ai, ci, az, cz, inc, gd, sk;
      logic [7:0] ea, ec;
      logic [47:0] p;
      logic [24:0] m;
      logic signed [10:0] ex;
      r = '0;
      s = a[31] ^ c[31];
      ea = a[30:23];
      ec = c[30:23];
      an = (ea == `PMN_EXP_ALL) && (a[22:0] != '0);
      cn = (ec == `PMN_EXP_ALL) && (c[22:0] != '0);
      ai = (ea == `PMN_EXP_ALL) && (a[22:0] == '0);
      ci = (ec == `PMN_EXP_ALL) && (c[22:0] == '0);
      az = (ea == '0) && (a[22:0] == '0);
      cz = (ec == '0) && (c[22:0] == '0);
      inc = 1'b0;
      gd = 1'b0;
      sk = 1'b0;
      m = '0;
      p = 48'({ea != '0, a[22:0]}) * 48'({ec != '0, c[22:0]});
      ex = 11'((ea == '0) ? 8'h01 : ea) + 11'((ec == '0) ? 8'h01 : ec)
           - `PMN_BIAS + 11'sh001;
      if (an || cn) begin
         // Quiet the first NaN operand; a signalling one flags invalid.
         r.res = (an ? a : c) | `PMN_QBIT;
         r.signalling_nan_invalid = (an && !a[22]) || (cn && !c[22]);
      end else if ((ai && cz) || (az && ci)) begin
         r.res = `PMN_QNAN;
         r.inf_times_zero_invalid = 1'b1;
      end else if (ai || ci) begin
         r.res = {s, `PMN_EXP_ALL, 23'h00_0000};
      end else if (az || cz) begin
         r.res = {s, 31'h0000_0000};
      end else begin
         for (int i = 0; i < `PMN_NORM_STEPS; i++) begin
            if (!p[47]) begin
               p = p << 1;
               ex = ex - 11'sh001;
            end
         end
         gd = p[23];
         sk = |p[22:0];
         case (rm)
            `PMN_RM_NEAR: inc = gd && (sk || p[24]);
            `PMN_RM_ZERO: inc = 1'b0;
            `PMN_RM_PINF: inc = !s && (gd || sk);
            default: inc = s && (gd || sk);
         endcase
         m = {1'b0, p[47:24]} + 25'(inc);
         if (m[24]) begin
            ex = ex + 11'sh001;
         end
         r.fr = inc;
         r.fi = gd || sk;
         r.xx = gd || sk;
         if (ex >= `PMN_EXP_TOP) begin
            r.ox = 1'b1;
            r.xx = 1'b1;
            r.fi = 1'b1;
            if (rm == `PMN_RM_ZERO || (rm == `PMN_RM_PINF && s) || (rm == `PMN_RM_NINF && !s)) begin
               r.res = {s, `PMN_MAXF};
            end else begin
               r.res = {s, `PMN_EXP_ALL, 23'h00_0000};
            end
         end else if (ex <= 11'sh000) begin
            r.ux = 1'b1;
            r.xx = 1'b1;
            r.fi = 1'b1;
            r.fr = 1'b0;
            r.res = {s, 31'h0000_0000};
         end else begin
            r.res = {s, ex[7:0], m[22:0]};
         end
      end
      return r;
   endfunction

   // Class and sign code of a single-precision value.
   function automatic logic [4:0] pmn_class(input logic [31:0] v);
      logic [4:0] k;
      if (v[30:23] == `PMN_EXP_ALL) begin
         k = (v[22:0] != '0) ? 5'h11 : (v[31] ? 5'h09 : 5'h05);
      end else if (v[30:23] == '0) begin
         k = (v[22:0] == '0) ? (v[31] ? 5'h12 : 5'h02) : (v[31] ? 5'h18 : 5'h14);
      end else begin
         k = v[31] ? 5'h08 : 5'h04;
      end
      return k;
   endfunction

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------

   // Bus slave, instruction execution and event flags in one pass. Every
   // transfer takes one wait state so that read data always comes from a
   // register and sees the result of a just-finished instruction.
   always_comb begin
      logic take, is_mul, is_neg, is_nabs, rc, inv_en, ok;
      logic [4:0] xo;
      logic [31:0] c0, c1, f, newb;
      logic [2:0] ev, clr;
      pmn_mul_t m0, m1;
      n = q;
      take = hsel && htrans[1] && hready;
      xo = q.instr[5:1];
      rc = q.instr[0];
      is_mul = 1'b0;
      is_neg = 1'b0;
      is_nabs = 1'b0;
      inv_en = 1'b0;
      ok = 1'b0;
      c0 = q.src[4];
      c1 = q.src[5];
      f = q.fp_status_control_reg;
      newb = '0;
      ev = '0;
      clr = '0;
      m0 = '0;
      m1 = '0;
      n.hresp = 1'b0;
      case (q.st)
         PMN_S_IDLE, PMN_S_EXEC: begin
            n.hready = 1'b1;
            n.st = PMN_S_IDLE;
            if (take) begin
               n.a_addr = haddr[7:0];
               n.a_map = (haddr[31:8] == '0);
               n.a_write = hwrite;
               n.hready = 1'b0;
               n.st = PMN_S_DATA;
            end
         end
         PMN_S_DATA: begin
            n.hready = 1'b1;
            n.st = PMN_S_IDLE;
            n.hrdata = '0;
            if (q.a_write && q.a_map) begin
               case (q.a_addr)
                  `PMN_OFF_CFG: n.paired_single_enable = hwdata[0];
                  `PMN_OFF_INSTR: begin
                     n.instr = hwdata;
                     n.st = PMN_S_EXEC;
                  end
                  `PMN_OFF_SRC_A0: n.src[0] = hwdata;
                  `PMN_OFF_SRC_A1: n.src[1] = hwdata;
                  `PMN_OFF_SRC_B0: n.src[2] = hwdata;
                  `PMN_OFF_SRC_B1: n.src[3] = hwdata;
                  `PMN_OFF_SRC_C0: n.src[4] = hwdata;
                  `PMN_OFF_SRC_C1: n.src[5] = hwdata;
                  `PMN_OFF_FP_STATUS_CONTROL_REG: n.fp_status_control_reg = hwdata;
                  `PMN_OFF_IRQ_MASK: n.mask = hwdata[2:0];
                  default: n.st = PMN_S_IDLE;
               endcase
            end else if (q.a_map) begin
               case (q.a_addr)
                  `PMN_OFF_CFG: n.hrdata = {31'h0000_0000, q.paired_single_enable};
                  `PMN_OFF_INSTR: n.hrdata = q.instr;
                  `PMN_OFF_SRC_A0: n.hrdata = q.src[0];
                  `PMN_OFF_SRC_A1: n.hrdata = q.src[1];
                  `PMN_OFF_SRC_B0: n.hrdata = q.src[2];
                  `PMN_OFF_SRC_B1: n.hrdata = q.src[3];
                  `PMN_OFF_SRC_C0: n.hrdata = q.src[4];
                  `PMN_OFF_SRC_C1: n.hrdata = q.src[5];
                  `PMN_OFF_FP_STATUS_CONTROL_REG: n.hrdata = q.fp_status_control_reg;
                  `PMN_OFF_RES0: n.hrdata = q.res0;
                  `PMN_OFF_RES1: n.hrdata = q.res1;
                  `PMN_OFF_STATUS: n.hrdata = {22'h00_0000, q.ill, q.dest, q.cr1};
                  `PMN_OFF_IRQ_STAT: begin
                     n.hrdata = {29'h0000_0000, q.stat};
                     clr = q.stat;
                  end
                  `PMN_OFF_IRQ_MASK: n.hrdata = {29'h0000_0000, q.mask};
                  default: n.hrdata = '0;
               endcase
            end
         end
         default: begin
            n.st = PMN_S_IDLE;
            n.hready = 1'b1;
         end
      endcase

      // Instruction execution, one cycle after the instruction word lands.
      if (q.st == PMN_S_EXEC) begin
         ev[`PMN_EV_DONE] = 1'b1;
         if (q.instr[31:26] == `PMN_OP_PRIMARY) begin
            if (xo == `PMN_XO_MUL && q.instr[15:11] == '0) begin
               is_mul = 1'b1;
            end
            if (xo == `PMN_XO_MULS0 && q.instr[15:11] == '0) begin
               is_mul = 1'b1;
               c1 = q.src[4];
            end
            if (xo == `PMN_XO_MULS1 && q.instr[15:11] == '0) begin
               is_mul = 1'b1;
               c0 = q.src[5];
            end
            is_nabs = (q.instr[10:1] == `PMN_XO_NABS) && (q.instr[20:16] == '0);
            is_neg = (q.instr[10:1] == `PMN_XO_NEG) && (q.instr[20:16] == '0);
         end
         ok = is_mul || is_neg || is_nabs;
         if (!q.paired_single_enable || !ok) begin
            ev[`PMN_EV_ILL] = 1'b1;
            n.ill = 1'b1;
         end else begin
            n.ill = 1'b0;
            n.dest = q.instr[25:21];
            if (is_mul) begin
               m0 = pmn_fmul(q.src[0], c0, q.fp_status_control_reg[`PMN_RN_HI:`PMN_RN_LO]);
               m1 = pmn_fmul(q.src[1], c1, q.fp_status_control_reg[`PMN_RN_HI:`PMN_RN_LO]);
               newb[`PMN_OX] = m0.ox || m1.ox;
               newb[`PMN_UX] = m0.ux || m1.ux;
               newb[`PMN_XX] = m0.xx || m1.xx;
               newb[`PMN_SIGNALLING_NAN_INVALID] = m0.signalling_nan_invalid || m1.signalling_nan_invalid;
               newb[`PMN_INF_TIMES_ZERO_INVALID] = m0.inf_times_zero_invalid || m1.inf_times_zero_invalid;
               // never raised by a product, so the sticky bit holds.
               newb[`PMN_INF_MINUS_INF_INVALID] = 1'b0;
               f = q.fp_status_control_reg | newb;
               f[`PMN_FR] = m0.fr || m1.fr;
               f[`PMN_FI] = m0.fi || m1.fi;
               f[`PMN_FX] = q.fp_status_control_reg[`PMN_FX] || ((newb & ~q.fp_status_control_reg) != '0);
               f[`PMN_VX] = (f & `PMN_VX_MASK) != '0;
               f[`PMN_FEX] = (f[`PMN_VX] && f[`PMN_VE]) || (f[`PMN_OX] && f[`PMN_OE])
                             || (f[`PMN_UX] && f[`PMN_UE]) || (f[`PMN_ZX] && f[`PMN_ZE])
                             || (f[`PMN_XX] && f[`PMN_XE]);
               inv_en = (newb[`PMN_SIGNALLING_NAN_INVALID] || newb[`PMN_INF_TIMES_ZERO_INVALID]) && q.fp_status_control_reg[`PMN_VE];
               if (!inv_en) begin
                  f[`PMN_RESULT_CLASS_SIGN_FIELD_HI:`PMN_RESULT_CLASS_SIGN_FIELD_LO] = pmn_class(m0.res);
                  n.res0 = m0.res;
                  n.res1 = m1.res;
               end
               n.fp_status_control_reg = f;
               ev[`PMN_EV_FEX] = f[`PMN_FEX];
            end else begin
               n.res0 = {is_nabs | ~q.src[2][31], q.src[2][30:0]};
               n.res1 = {is_nabs | ~q.src[3][31], q.src[3][30:0]};
            end
            if (rc) begin
               n.cr1 = {f[`PMN_FX], f[`PMN_FEX], f[`PMN_VX], f[`PMN_OX]};
            end
         end
      end

      // Sticky events; a new event in the cycle of a clearing read is kept.
      n.stat = (q.stat & ~clr) | ev;
      n.irq = |(n.stat & n.mask);
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------

   // All state lives in one struct, reset to constants only.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= PMN_RST;
      end else begin
         q <= n;
      end
   end

   // Outputs come straight from the state register.
   assign hreadyout = q.hready;
   assign hrdata = q.hrdata;
   assign hresp = q.hresp;
   assign irq = q.irq;

endmodule // pmn_unit

// ### pmn_unit_assertions.sv
// Port-level checker for the paired-single multiply and negate unit.
// Assumes one bus master whose hready is the unit's own hreadyout.
`timescale 1ns/1ps

module pmn_unit_checker (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   input wire logic irq
);
   logic taken;
   logic rise_src;
   logic fall_src;
   logic [2:0] wcnt;
   logic [2:0] rcnt;

   // --------------------------------------------------------------
   // Helper logic
   // --------------------------------------------------------------
   // Only an instruction or mask write may raise irq; only a status read or mask write lowers it.
   assign taken = hsel & htrans[1] & hready;
   assign rise_src = taken & hwrite & (haddr == 32'h0000_0004 || haddr == 32'h0000_0034);
   assign fall_src = taken & (haddr == 32'h0000_0030 || haddr == 32'h0000_0034);

   // Saturating distances, so a stale cause never excuses a late edge.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wcnt <= 3'h7;
         rcnt <= 3'h7;
      end else begin
         wcnt <= rise_src ? 3'h0 : wcnt + {2'h0, wcnt != 3'h7};
         rcnt <= fall_src ? 3'h0 : rcnt + {2'h0, rcnt != 3'h7};
      end
   end

   // --------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_resp_okay: assert property (hresp == 1'b0)
      else $error("Response was not OKAY.");
   a_wait_one: assert property (taken |=> !hreadyout ##1 hreadyout)
      else $error("Wait state was not exactly one cycle.");
   a_no_idle_wait: assert property (!taken && hreadyout |=> hreadyout)
      else $error("Wait state without a transfer.");
   a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
      else $error("Read data moved outside a read.");
   a_unmapped_zero: assert property (taken && !hwrite && |haddr[31:8] |-> ##2 hrdata == 32'h0000_0000)
      else $error("Unmapped read returned data.");
   a_irq_rise_cause: assert property ($rose(irq) |-> wcnt <= 3'h5)
      else $error("Interrupt rose without a cause.");
   a_irq_fall_cause: assert property ($fell(irq) |-> rcnt <= 3'h5)
      else $error("Interrupt fell without a clear.");
   a_reset_quiet: assert property ($rose(hresetn) |-> hreadyout && !irq && hrdata == 32'h0000_0000)
      else $error("Outputs not at reset values.");
endmodule // pmn_unit_checker

// ### pmn_host_bfm.sv
// Bus master standing in for the dispatch logic in front of the unit.
// Assumes it is called right after a rising edge, one transfer at a time.
`timescale 1ns/1ps

module pmn_host_bfm (
   input wire logic hclk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   bit tmo;

   // Idle bus at time zero.
   initial begin
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
   end

   // Bounded wait; a stuck slave raises tmo instead of hanging the run.
   task automatic wait_ready();
      int n;
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1 && n < 64) begin
         @(posedge hclk);
         n++;
      end
      if (hready !== 1'b1) tmo = 1'b1;
   endtask

   // One word transfer; released address lines show the inverse, not the old value.
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      hsize <= 3'b010;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'b00;
      haddr <= ~a;
      hwdata <= wr ? d : ~hwdata;
      wait_ready();
      r = hrdata;
   endtask
endmodule // pmn_host_bfm

// ### tb.sv
// Self-checking bench for the paired-single unit, driven over its register bus.
// Assumes the unit's hand-over register map and one-wait-state timing.
`timescale 1ns/1ps
`include "pmn_defs.svh"

module tb;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [1:0] htrans;
   logic [2:0] hsize;
   int errors, num_checks;
   logic [9:0] xo_t [5] = '{10'h019, 10'h00C, 10'h00D, 10'h088, 10'h028};
   logic [31:0] e0_t [5] = '{32'h40C0_0000, 32'h40C0_0000, 32'hC080_0000, 32'hFFC0_0000,
                             32'hFFC0_0000};
   logic [31:0] e1_t [5] = '{32'hC040_0000, 32'h4090_0000, 32'hC040_0000, 32'hC040_0000,
                             32'h4040_0000};
   logic [31:0] fp_t [5] = '{32'h0000_4001, 32'h0000_4001, 32'h0000_8001, 32'h0000_8001,
                             32'h0000_8001};
   logic [31:0] opnd [6] = '{32'h4000_0000, 32'h3FC0_0000, 32'h7FC0_0000, 32'hC040_0000,
                             32'h4040_0000, 32'hC000_0000};

   pmn_unit i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq));
   pmn_host_bfm i_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   // --------------------------------------------------------------
   // Tasks
   // --------------------------------------------------------------
   // Verdict; a bus timeout counts as a mismatch.
   task automatic end_of_test();
      errors += i_host.tmo;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
      i_host.xfer(wr, {24'h00_0000, a}, d, r);
      if (i_host.tmo) end_of_test();
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      acc(1'b0, a, 32'h0000_0000);
      chk(r, exp);
   endtask

   function automatic logic [31:0] ins(input logic [9:0] xo, input logic [4:0] d, input logic rc);
      return 32'h1000_0000 | (32'(d) << 21) | (32'(xo) << 1) | 32'(rc);
   endfunction

   // --------------------------------------------------------------
   // Clock and sequence
   // --------------------------------------------------------------
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end

   initial begin
      hresetn = 1'b0;
      errors = 0;
      num_checks = 0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rdc(`PMN_OFF_CFG, 32'h0000_0000);
      rdc(`PMN_OFF_FP_STATUS_CONTROL_REG, 32'h0000_0000);
      acc(1'b1, `PMN_OFF_IRQ_MASK, 32'h0000_0003);
      acc(1'b1, `PMN_OFF_INSTR, ins(10'h019, 5'd0, 1'b0));
      rdc(`PMN_OFF_STATUS, 32'h0000_0200);
      rdc(`PMN_OFF_RES0, 32'h0000_0000);
      chk(32'(irq), 32'h0000_0001);
      rdc(`PMN_OFF_IRQ_STAT, 32'h0000_0003);
      rdc(`PMN_OFF_IRQ_STAT, 32'h0000_0000);
      chk(32'(irq), 32'h0000_0000);
      acc(1'b1, `PMN_OFF_CFG, 32'h0000_0001);
      foreach (opnd[i]) acc(1'b1, 8'(8 + 4 * i), opnd[i]);
      for (int i = 0; i < 5; i++) begin
         if (i < 3) acc(1'b1, `PMN_OFF_FP_STATUS_CONTROL_REG, 32'h0000_0001);
         acc(1'b1, `PMN_OFF_INSTR, ins(xo_t[i], 5'(i + 3), 1'b0));
         rdc(`PMN_OFF_RES0, e0_t[i]);
         rdc(`PMN_OFF_RES1, e1_t[i]);
         rdc(`PMN_OFF_FP_STATUS_CONTROL_REG, fp_t[i]);
         rdc(`PMN_OFF_STATUS, 32'((i + 3) << 4));
      end
      acc(1'b1, `PMN_OFF_SRC_A0, 32'h3F80_0001);
      acc(1'b1, `PMN_OFF_SRC_C0, 32'h3F80_0001);
      for (int m = 0; m < 4; m += 2) begin
         acc(1'b1, `PMN_OFF_FP_STATUS_CONTROL_REG, 32'(m));
         acc(1'b1, `PMN_OFF_INSTR, ins(10'h019, 5'd1, 1'b0));
         rdc(`PMN_OFF_RES0, m ? 32'h3F80_0003 : 32'h3F80_0002);
         rdc(`PMN_OFF_FP_STATUS_CONTROL_REG, m ? 32'h8206_4002 : 32'h8202_4000);
      end
      acc(1'b1, `PMN_OFF_SRC_A0, 32'h4000_0000);
      acc(1'b1, `PMN_OFF_SRC_C0, 32'h4040_0000);
      acc(1'b1, `PMN_OFF_SRC_A1, 32'h7F00_0000);
      acc(1'b1, `PMN_OFF_SRC_C1, 32'h7F00_0000);
      acc(1'b1, `PMN_OFF_FP_STATUS_CONTROL_REG, 32'h0000_0000);
      acc(1'b1, `PMN_OFF_INSTR, ins(10'h019, 5'd2, 1'b1));
      rdc(`PMN_OFF_RES1, 32'h7F80_0000);
      acc(1'b0, `PMN_OFF_FP_STATUS_CONTROL_REG, 32'h0000_0000);
      chk(r, 32'h9202_4000);
      rdc(`PMN_OFF_STATUS, 32'h0000_0029);
      acc(1'b1, `PMN_OFF_INSTR, ins(10'h019, 5'd2, 1'b0) | 32'h0000_0800);
      acc(1'b0, `PMN_OFF_STATUS, 32'h0000_0000);
      chk(r & 32'h0000_0200, 32'h0000_0200);
      rdc(`PMN_OFF_RES1, 32'h7F80_0000);
      rdc(`PMN_OFF_IRQ_STAT, 32'h0000_0003);
      // Masked event stays off the interrupt line.
      acc(1'b1, `PMN_OFF_IRQ_MASK, 32'h0000_0000);
      acc(1'b1, `PMN_OFF_INSTR, ins(10'h028, 5'd4, 1'b0));
      rdc(`PMN_OFF_IRQ_MASK, 32'h0000_0000);
      chk(32'(irq), 32'h0000_0000);
      rdc(`PMN_OFF_IRQ_STAT, 32'h0000_0001);
      i_host.xfer(1'b0, 32'h0000_0100, 32'h0000_0000, r);
      chk(r, 32'h0000_0000);
      // Enabled invalid: infinity times zero in lane 0, overflow in lane 1.
      acc(1'b1, `PMN_OFF_SRC_A0, 32'h7F80_0000);
      acc(1'b1, `PMN_OFF_SRC_C0, 32'h0000_0000);
      acc(1'b1, `PMN_OFF_FP_STATUS_CONTROL_REG, 32'h0000_0080);
      acc(1'b1, `PMN_OFF_INSTR, ins(10'h019, 5'd5, 1'b1));
      rdc(`PMN_OFF_RES0, 32'hFFC0_0000);
      rdc(`PMN_OFF_FP_STATUS_CONTROL_REG, 32'hF212_0080);
      rdc(`PMN_OFF_STATUS, 32'h0000_005F);
      rdc(`PMN_OFF_IRQ_STAT, 32'h0000_0005);
      end_of_test();
   end
endmodule // tb

bind pmn_unit pmn_unit_checker i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq));
